//--- ntla_params.svh
`ifndef NTLA_PARAMS_SVH
`define NTLA_PARAMS_SVH
`define NTLA_CLK_HZ 100000000
`define NTLA_TN1_MS 13
`define NTLA_T2_MS 1
`define NTLA_AWAKE_US 4000
`define NTLA_AWAKE_GAP_US 4000
`define NTLA_TONE_HZ 7500
`define NTLA_CNT_W 32
// Line transmit codes
`define NTLA_LTX_SIG0 4'h0
`define NTLA_LTX_SIG1W 4'h1
`define NTLA_LTX_SIG1A 4'h2
`define NTLA_LTX_SIG1 4'h3
`define NTLA_LTX_SIG3 4'h4
`define NTLA_LTX_SIG5 4'h5
// User transmit codes
`define NTLA_UTX_INFO0 3'h0
`define NTLA_UTX_INFO2 3'h2
`define NTLA_UTX_INFO4 3'h4
`define NTLA_UTX_INFOX 3'h7
`endif

//--- ntla_pkg.sv
package ntla_pkg;
	typedef enum logic [11:0] {
		NTLA_S11 = 12'h001,
		NTLA_S12 = 12'h002,
		NTLA_S13 = 12'h004,
		NTLA_S14 = 12'h008,
		NTLA_S15 = 12'h010,
		NTLA_S16 = 12'h020,
		NTLA_S17 = 12'h040,
		NTLA_S18 = 12'h080,
		NTLA_S19 = 12'h100,
		NTLA_S110 = 12'h200,
		NTLA_S21 = 12'h400,
		NTLA_S22 = 12'h800
	} ntla_state_t;
endpackage

//--- ntla_timer.sv
`timescale 1ns/1ps
`include "ntla_params.svh"
module ntla_timer #(
	parameter int CNT_W = `NTLA_CNT_W
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic [CNT_W-1:0] load_i,
	output logic run_o,
	output logic expire_o
);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic run_nxt;
	logic exp_nxt;
	wire last_w = run_o && (cnt_r == {CNT_W{1'b0}});

	// Restart always reloads full count
	assign cnt_nxt = start_i ? load_i : (run_o && !last_w) ? cnt_r - 1'b1 : cnt_r;
	assign run_nxt = start_i ? 1'b1 : (stop_i || last_w) ? 1'b0 : run_o;
	assign exp_nxt = !start_i && !stop_i && last_w;

	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			cnt_r <= '0;
			run_o <= 1'b0;
			expire_o <= 1'b0;
		end
		else if (ce_i)
		begin
			cnt_r <= cnt_nxt;
			run_o <= run_nxt;
			expire_o <= exp_nxt;
		end
	end
endmodule

//--- ntla_core.sv
`timescale 1ns/1ps
`include "ntla_params.svh"
// Summary of operation
// RQ1: Deactivated: send nothing, await wake-up
// RQ2: INFO 1 when deactivated: send awake tone
// RQ3: Awake acknowledge moves to sync wait
// RQ4: Line awake: start Tn1, answer tone
// RQ5: Tn1 expiry: send unframed SIG 1A
// RQ6: Receiver synchronised on SIG 2: advance
// RQ7: Send SIG 1, INFO 2; INFO 3 advances
// RQ8: Send SIG 3; SIG 4H gives active
// RQ9: Active: INFO 4 and SIG 5 sent
// RQ10: SIG 0 starts T2, pending deactivation
// RQ11: INFO 0 or T2 expiry deactivates
// RQ12: User framing loss: hold, INFO 3 restores
// RQ13: Line framing loss: INFO X, SIG 0
// RQ14: Loopback request: SIG 3, INFO 2
// RQ15: Loopback 2 returns user data; the code loops line data back to the line
// RQ16: D-echo forced zero during loopback
// RQ17: Far end answers tone, Tl1 7 ms
// RQ18: Far end wakes with SIG 2W
// RQ19: Far end sends SIG 2 while syncing
// RQ20: Far end sends SIG 4H for 1 ms
// RQ21: Far end loopback 1 waits 12 ms
// RQ22: Network delays activation indication 1 ms
// RQ23: Awake signals are 7.5 kHz bursts
// RQ24: Awake bursts limited, repeated if unanswered
// RQ25: Impossible events change nothing; reset deactivates
// RQ26: Timers count cycles, restart from zero
module ntla_core #(
	parameter int CLK_HZ = `NTLA_CLK_HZ,
	parameter int TN1_CYC = (`NTLA_TN1_MS * (CLK_HZ / 1000)),
	parameter int T2_CYC = (`NTLA_T2_MS * (CLK_HZ / 1000)),
	parameter int AWAKE_CYC = (`NTLA_AWAKE_US * (CLK_HZ / 1000000)),
	parameter int GAP_CYC = (`NTLA_AWAKE_GAP_US * (CLK_HZ / 1000000)),
	parameter int TONE_HALF_CYC = (CLK_HZ / (2 * `NTLA_TONE_HZ))
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic rx_info0_i,
	input wire logic rx_info1_i,
	input wire logic rx_info3_i,
	input wire logic user_frame_lost_i,
	input wire logic rx_sig0_i,
	input wire logic rx_sig2w_i,
	input wire logic line_sync_i,
	input wire logic rx_sig2l2_i,
	input wire logic rx_sig4h_i,
	input wire logic rx_sig4hl2_i,
	input wire logic rx_sig4_i,
	input wire logic rx_sig4l2_i,
	input wire logic line_frame_lost_i,
	input wire logic [17:0] user_data_i,
	input wire logic [17:0] line_data_i,
	input wire logic user_decho_i,
	output logic [3:0] line_tx_o,
	output logic line_tone_o,
	output logic [2:0] user_tx_o,
	output logic [17:0] line_data_o,
	output logic [17:0] user_data_o,
	output logic user_decho_o,
	output logic low_power_o,
	output logic [11:0] state_o
);
	localparam int CW = `NTLA_CNT_W;

	// ----------------------------------------
	// State and timers
	// ----------------------------------------
	ntla_pkg::ntla_state_t state_r;
	ntla_pkg::ntla_state_t state_nxt;
	logic tn1_run;
	logic tn1_exp;
	logic t2_exp;
	logic tn1_start;
	logic t2_start;

	function automatic logic [CW-1:0] cyc(input int n);
		cyc = (n < 1) ? CW'(0) : CW'(n - 1);
	endfunction

	// RQ26: cycle-based restartable timers
	ntla_timer #(.CNT_W(CW)) u_tn1 (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.start_i(tn1_start),
		.stop_i(state_r != ntla_pkg::NTLA_S13),
		.load_i(cyc(TN1_CYC)),
		.run_o(tn1_run),
		.expire_o(tn1_exp)
	);

	ntla_timer #(.CNT_W(CW)) u_t2 (
		.clock_i(clock_i),
		.rstn_i(rstn_i),
		.ce_i(ce_i),
		.start_i(t2_start),
		.stop_i(state_r != ntla_pkg::NTLA_S18),
		.load_i(cyc(T2_CYC)),
		.run_o(),
		.expire_o(t2_exp)
	);

	// ----------------------------------------
	// Event decode
	// ----------------------------------------
	wire st_11 = (state_r == ntla_pkg::NTLA_S11);
	wire st_13 = (state_r == ntla_pkg::NTLA_S13);
	wire st_18 = (state_r == ntla_pkg::NTLA_S18);
	wire in_sig0_zone = !(st_11 || st_18 || state_r == ntla_pkg::NTLA_S12 || st_13);
	wire line_lost_zone = (state_r == ntla_pkg::NTLA_S15) || (state_r == ntla_pkg::NTLA_S16) ||
		(state_r == ntla_pkg::NTLA_S17) || (state_r == ntla_pkg::NTLA_S19) ||
		(state_r == ntla_pkg::NTLA_S21) || (state_r == ntla_pkg::NTLA_S22);
	// RQ10: SIG 0 deactivation from all states except S11, S12, S13 and S18
	wire go_deact = rx_sig0_i && in_sig0_zone;
	// RQ13: line framing loss detect
	wire go_line_lost = !go_deact && line_frame_lost_i && line_lost_zone;
	// RQ4: line-initiated awake
	assign tn1_start = ce_i && ((st_11 && rx_sig2w_i) || (st_13 && rx_sig2w_i));
	assign t2_start = ce_i && go_deact;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		// RQ25: default holds state
		state_nxt = state_r;
		if (go_deact)
			state_nxt = ntla_pkg::NTLA_S18;
		else if (go_line_lost)
			state_nxt = ntla_pkg::NTLA_S110;
		else
		begin
			case (state_r)
				ntla_pkg::NTLA_S11:
				begin
					// RQ4: line awake wins over user
					if (rx_sig2w_i)
						state_nxt = ntla_pkg::NTLA_S13;
					// RQ2: user wake-up
					else if (rx_info1_i)
						state_nxt = ntla_pkg::NTLA_S12;
				end
				ntla_pkg::NTLA_S12:
				begin
					// RQ3: awake acknowledged
					if (rx_sig2w_i)
						state_nxt = ntla_pkg::NTLA_S14;
				end
				ntla_pkg::NTLA_S13:
				begin
					// RQ5: Tn1 expiry, new SIG 2W blocks
					if (tn1_exp && !rx_sig2w_i && !tn1_run)
						state_nxt = ntla_pkg::NTLA_S14;
				end
				ntla_pkg::NTLA_S14:
				begin
					// RQ14: loopback 2 request
					if (rx_sig2l2_i)
						state_nxt = ntla_pkg::NTLA_S21;
					// RQ6: synchronised on SIG 2
					else if (line_sync_i)
						state_nxt = ntla_pkg::NTLA_S15;
				end
				ntla_pkg::NTLA_S15:
				begin
					// RQ7: INFO 3 advances
					if (rx_info3_i)
						state_nxt = ntla_pkg::NTLA_S16;
				end
				ntla_pkg::NTLA_S16:
				begin
					// RQ8: SIG 4H gives active
					if (rx_sig4h_i)
						state_nxt = ntla_pkg::NTLA_S17;
					else if (rx_sig4hl2_i)
						state_nxt = ntla_pkg::NTLA_S22;
				end
				ntla_pkg::NTLA_S17:
				begin
					// RQ12: user-side loss or INFO 0
					if (user_frame_lost_i || rx_info0_i)
						state_nxt = ntla_pkg::NTLA_S19;
					else if (rx_sig4l2_i)
						state_nxt = ntla_pkg::NTLA_S22;
				end
				ntla_pkg::NTLA_S18:
				begin
					// RQ11: INFO 0 or T2 expiry
					if (rx_info0_i || t2_exp)
						state_nxt = ntla_pkg::NTLA_S11;
				end
				ntla_pkg::NTLA_S19:
				begin
					// RQ12: INFO 3 restores active
					if (rx_info3_i)
						state_nxt = ntla_pkg::NTLA_S17;
					else if (rx_sig4l2_i)
						state_nxt = ntla_pkg::NTLA_S22;
				end
				ntla_pkg::NTLA_S110:
				begin
					if (rx_sig4l2_i)
						state_nxt = ntla_pkg::NTLA_S22;
				end
				ntla_pkg::NTLA_S21:
				begin
					// RQ14: await SIG 4H-L2
					if (rx_sig4hl2_i)
						state_nxt = ntla_pkg::NTLA_S22;
					else if (rx_sig4h_i)
						state_nxt = ntla_pkg::NTLA_S17;
				end
				ntla_pkg::NTLA_S22:
				begin
					if (rx_sig4_i)
						state_nxt = ntla_pkg::NTLA_S17;
				end
				default:
					state_nxt = ntla_pkg::NTLA_S11;
			endcase
		end
	end

	// ----------------------------------------
	// Awake burst generator
	// ----------------------------------------
	// Bursts repeat with a gap so the far end can answer between them.
	logic [CW-1:0] burst_r;
	logic [CW-1:0] burst_nxt;
	logic [CW-1:0] half_r;
	logic [CW-1:0] half_nxt;
	logic tone_r;
	logic tone_nxt;
	wire awake_w = (state_nxt == ntla_pkg::NTLA_S12) || (state_nxt == ntla_pkg::NTLA_S13);
	wire in_burst_w = burst_r < CW'(AWAKE_CYC);
	wire burst_wrap_w = burst_r >= cyc(AWAKE_CYC + GAP_CYC);
	wire half_wrap_w = half_r >= cyc(TONE_HALF_CYC);
	// RQ24: limited burst, repeated
	assign burst_nxt = (!awake_w || burst_wrap_w) ? '0 : burst_r + 1'b1;
	assign half_nxt = (!awake_w || half_wrap_w) ? '0 : half_r + 1'b1;
	// RQ23: 7.5 kHz tone toggling
	assign tone_nxt = (awake_w && in_burst_w) ? (half_wrap_w ? !tone_r : tone_r) : 1'b0;

	// ----------------------------------------
	// Output decode
	// ----------------------------------------
	logic [3:0] ltx_nxt;
	logic [2:0] utx_nxt;
	wire loop_w = (state_nxt == ntla_pkg::NTLA_S22);
	wire pass_w = (state_nxt == ntla_pkg::NTLA_S17) || loop_w;

	always_comb
	begin
		ltx_nxt = `NTLA_LTX_SIG0;
		utx_nxt = `NTLA_UTX_INFO0;
		case (state_nxt)
			// RQ1: nothing sent when deactivated
			ntla_pkg::NTLA_S11: ltx_nxt = `NTLA_LTX_SIG0;
			// RQ2: awake tone toward line
			ntla_pkg::NTLA_S12: ltx_nxt = `NTLA_LTX_SIG1W;
			ntla_pkg::NTLA_S13: ltx_nxt = `NTLA_LTX_SIG1W;
			// RQ5: unframed SIG 1A
			ntla_pkg::NTLA_S14: ltx_nxt = `NTLA_LTX_SIG1A;
			ntla_pkg::NTLA_S15:
			begin
				// RQ7: SIG 1 and INFO 2
				ltx_nxt = `NTLA_LTX_SIG1;
				utx_nxt = `NTLA_UTX_INFO2;
			end
			ntla_pkg::NTLA_S16:
			begin
				// RQ8: SIG 3, INFO 2 kept
				ltx_nxt = `NTLA_LTX_SIG3;
				utx_nxt = `NTLA_UTX_INFO2;
			end
			ntla_pkg::NTLA_S17:
			begin
				// RQ9: fully active
				ltx_nxt = `NTLA_LTX_SIG5;
				utx_nxt = `NTLA_UTX_INFO4;
			end
			// RQ10: INFO 0 and SIG 0
			ntla_pkg::NTLA_S18: ltx_nxt = `NTLA_LTX_SIG0;
			ntla_pkg::NTLA_S19:
			begin
				// RQ12: no indication to line
				ltx_nxt = `NTLA_LTX_SIG5;
				utx_nxt = `NTLA_UTX_INFO2;
			end
			// RQ13: INFO X and SIG 0
			ntla_pkg::NTLA_S110: utx_nxt = `NTLA_UTX_INFOX;
			ntla_pkg::NTLA_S21:
			begin
				// RQ14: SIG 3 and INFO 2
				ltx_nxt = `NTLA_LTX_SIG3;
				utx_nxt = `NTLA_UTX_INFO2;
			end
			ntla_pkg::NTLA_S22:
			begin
				// RQ15: loopback 2 operated
				ltx_nxt = `NTLA_LTX_SIG5;
				utx_nxt = `NTLA_UTX_INFO4;
			end
			default:
			begin
				ltx_nxt = `NTLA_LTX_SIG0;
				utx_nxt = `NTLA_UTX_INFO0;
			end
		endcase
	end

	// RQ15: loop received data back to line
	wire [17:0] ldata_nxt = loop_w ? line_data_i : (pass_w ? user_data_i : 18'h00000);
	wire [17:0] udata_nxt = pass_w ? line_data_i : 18'h00000;
	// RQ16: D-echo zero in loopback
	wire decho_nxt = (state_nxt == ntla_pkg::NTLA_S17) ? user_decho_i : 1'b0;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			// RQ25: reset deactivates
			state_r <= ntla_pkg::NTLA_S11;
			burst_r <= '0;
			half_r <= '0;
			tone_r <= 1'b0;
			line_tx_o <= `NTLA_LTX_SIG0;
			line_tone_o <= 1'b0;
			user_tx_o <= `NTLA_UTX_INFO0;
			line_data_o <= 18'h00000;
			user_data_o <= 18'h00000;
			user_decho_o <= 1'b0;
			low_power_o <= 1'b1;
			state_o <= ntla_pkg::NTLA_S11;
		end
		else if (ce_i)
		begin
			state_r <= state_nxt;
			burst_r <= burst_nxt;
			half_r <= half_nxt;
			tone_r <= tone_nxt;
			line_tx_o <= ltx_nxt;
			line_tone_o <= tone_nxt;
			user_tx_o <= utx_nxt;
			line_data_o <= ldata_nxt;
			user_data_o <= udata_nxt;
			user_decho_o <= decho_nxt;
			low_power_o <= (state_nxt == ntla_pkg::NTLA_S11);
			state_o <= state_nxt;
		end
	end
endmodule

//--- ntla_properties.sv
`timescale 1ns/1ps
module ntla_properties #(
	parameter int TN1_CYC = 20,
	parameter int T2_CYC = 10
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic ce_i,
	input wire logic rx_info0_i,
	input wire logic rx_info1_i,
	input wire logic rx_sig0_i,
	input wire logic rx_sig2w_i,
	input wire logic rx_sig2l2_i,
	input wire logic user_frame_lost_i,
	input wire logic line_frame_lost_i,
	input wire logic [17:0] line_data_i,
	input wire logic [3:0] line_tx_o,
	input wire logic line_tone_o,
	input wire logic [2:0] user_tx_o,
	input wire logic [17:0] line_data_o,
	input wire logic user_decho_o,
	input wire logic [11:0] state_o
);
	localparam int TN1_MAX = TN1_CYC + 2;
	localparam int T2_MAX = T2_CYC + 2;
	logic [31:0] wait_r;
	// ----
	// Checks
	// ----
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	// Restarts on every SIG 2W and whenever not in S13
	always_ff @(posedge clock_i or negedge rstn_i)
		if (!rstn_i)
			wait_r <= '0;
		else
			wait_r <= (state_o[2] && !rx_sig2w_i) ? wait_r + 32'h1 : '0;
	sequence s_awake;
		state_o == 12'h002 && line_tx_o == 4'h1;
	endsequence
	sequence s_deact;
		state_o == 12'h080 && line_tx_o == 4'h0 && user_tx_o == 3'h0;
	endsequence
	idle_quiet_a: assert property (
		state_o == 12'h001 |-> line_tx_o == 4'h0 && user_tx_o == 3'h0) else $error("idle out");
	user_wake_a: assert property (
		ce_i && state_o == 12'h001 && rx_info1_i && !rx_sig2w_i |=> s_awake) else $error("wake");
	wake_ack_a: assert property (
		(ce_i && rx_sig2w_i && !rx_sig0_i) and s_awake |=> state_o == 12'h008) else $error("ack");
	line_wake_a: assert property (
		ce_i && state_o == 12'h001 && rx_sig2w_i |=> state_o == 12'h004 && line_tx_o == 4'h1)
		else $error("line wake");
	tn1_bound_a: assert property (
		state_o[2] |-> wait_r <= TN1_MAX) else $error("tn1 late");
	sig0_deact_a: assert property (
		ce_i && rx_sig0_i && |(state_o & 12'hf78) |=> s_deact) else $error("deact");
	t2_bound_a: assert property (
		$rose(state_o[7]) |-> ##[1:T2_MAX] state_o == 12'h001) else $error("t2 late");
	user_loss_a: assert property (
		ce_i && state_o == 12'h040 && user_frame_lost_i && !rx_sig0_i && !line_frame_lost_i
		|=> state_o == 12'h100 && line_tx_o == 4'h5) else $error("user loss");
	line_loss_a: assert property (
		ce_i && line_frame_lost_i && !rx_sig0_i && |(state_o & 12'hd70)
		|=> state_o == 12'h200 && user_tx_o == 3'h7 && line_tx_o == 4'h0) else $error("line loss");
	loop_req_a: assert property (
		ce_i && state_o == 12'h008 && rx_sig2l2_i && !rx_sig0_i
		|=> state_o == 12'h400 && line_tx_o == 4'h4 && user_tx_o == 3'h2) else $error("loop");
	loop_data_a: assert property (
		state_o == 12'h800 |-> line_data_o == $past(line_data_i) && !user_decho_o)
		else $error("loop data");
	tone_quiet_a: assert property (
		!(state_o[1] || state_o[2]) |-> !line_tone_o) else $error("tone out");
	info0_exit_a: assert property (
		ce_i && state_o == 12'h080 && rx_info0_i |=> state_o == 12'h001) else $error("info0");
endmodule
bind ntla_core ntla_properties #(.TN1_CYC(TN1_CYC), .T2_CYC(T2_CYC)) ntla_properties_inst (
	.clock_i, .rstn_i, .ce_i, .rx_info0_i, .rx_info1_i, .rx_sig0_i, .rx_sig2w_i, .rx_sig2l2_i,
	.user_frame_lost_i, .line_frame_lost_i, .line_data_i, .line_tx_o, .line_tone_o,
	.user_tx_o, .line_data_o, .user_decho_o, .state_o);

//--- ntla_lt_model.sv
`timescale 1ns/1ps
module ntla_lt_model #(
	parameter int TL1_CYC = 6,
	parameter int TL2_CYC = 5,
	parameter int TL3_CYC = 3
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic wake_i,
	input wire logic drop_i,
	input wire logic loop_i,
	input wire logic [3:0] line_tx_i,
	output logic sig2w_o,
	output logic sig2_o,
	output logic sig4h_o,
	output logic sig4hl2_o,
	output logic sig4_o,
	output logic sig4l2_o,
	output logic sig0_o,
	output logic act_o
);
	int cnt = 0;
	logic [2:0] st_r = 3'h0;
	// ----
	// Exchange end
	// ----
	assign sig0_o = drop_i;
	// exchange told Tl3 after SIG 4
	assign act_o = st_r == 3'h4 && cnt >= TL2_CYC + TL3_CYC;
	assign sig2_o = st_r == 3'h2;
	assign sig4h_o = st_r == 3'h3 && !loop_i;
	assign sig4hl2_o = st_r == 3'h3 && loop_i;
	assign sig4_o = st_r == 3'h4 && !loop_i;
	assign sig4l2_o = st_r == 3'h4 && loop_i;
	always @(posedge clock_i or negedge rstn_i)
	begin
		sig2w_o <= 1'b0;
		cnt <= cnt + 1;
		if (!rstn_i || drop_i)
			st_r <= 3'h0;
		else if (wake_i || (st_r == 3'h0 && line_tx_i == 4'h1))
		begin
			sig2w_o <= 1'b1;
			cnt <= 0;
			st_r <= 3'h1;
		end
		else if (st_r == 3'h1 && cnt >= TL1_CYC)
			st_r <= 3'h2;
		else if (st_r == 3'h2 && line_tx_i == 4'h4)
		begin
			cnt <= 0;
			st_r <= 3'h3;
		end
		else if (st_r == 3'h3 && cnt >= TL2_CYC - 1)
			st_r <= 3'h4;
	end
endmodule

//--- ntla_core_test.sv
`timescale 1ns/1ps
module ntla_core_test;
	localparam int TN1 = 20;
	localparam int T2 = 10;
	logic clock_i = 1'b0;
	logic rstn_i = 1'b0;
	logic ce_i = 1'b1;
	logic rx_info0_i = 1'b0, rx_info1_i = 1'b0, rx_info3_i = 1'b0, rx_sig2l2_i = 1'b0;
	logic user_frame_lost_i = 1'b0, line_frame_lost_i = 1'b0, user_decho_i = 1'b0;
	logic wake = 1'b0, drop = 1'b0, loop = 1'b0;
	logic [17:0] user_data_i = 18'h0, line_data_i = 18'h0;
	logic rx_sig0_i, rx_sig2w_i, line_sync_i, rx_sig4h_i, rx_sig4hl2_i, rx_sig4_i, rx_sig4l2_i;
	logic line_tone_o, user_decho_o, low_power_o, lt_act;
	logic [3:0] line_tx_o;
	logic [2:0] user_tx_o;
	logic [17:0] line_data_o, user_data_o;
	logic [11:0] state_o;
	int miscompares = 0;
	int num_checks = 0;
	int n;
	int hi;
	ntla_core #(.TN1_CYC(TN1), .T2_CYC(T2), .AWAKE_CYC(8), .GAP_CYC(8), .TONE_HALF_CYC(2))
	ntla_core_inst (.clock_i, .rstn_i, .ce_i, .rx_info0_i, .rx_info1_i, .rx_info3_i,
		.user_frame_lost_i, .rx_sig0_i, .rx_sig2w_i, .line_sync_i, .rx_sig2l2_i, .rx_sig4h_i,
		.rx_sig4hl2_i, .rx_sig4_i, .rx_sig4l2_i, .line_frame_lost_i, .user_data_i, .line_data_i,
		.user_decho_i, .line_tx_o, .line_tone_o, .user_tx_o, .line_data_o, .user_data_o,
		.user_decho_o, .low_power_o, .state_o);
	ntla_lt_model ntla_lt_model_inst (.clock_i, .rstn_i, .wake_i(wake), .drop_i(drop),
		.loop_i(loop), .line_tx_i(line_tx_o), .sig2w_o(rx_sig2w_i), .sig2_o(line_sync_i),
		.sig4h_o(rx_sig4h_i), .sig4hl2_o(rx_sig4hl2_i), .sig4_o(rx_sig4_i),
		.sig4l2_o(rx_sig4l2_i), .sig0_o(rx_sig0_i), .act_o(lt_act));
	// ----
	// Helpers
	// ----
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [17:0] exp, input logic [17:0] got);
		num_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask
	// Drive just after the edge so no race with sampling
	task automatic tick(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask
	task automatic wait_st(input logic [11:0] s, input int lim);
		n = 0;
		while (state_o !== s && n < lim)
		begin
			tick(1);
			n++;
		end
		chk("state", s, state_o);
		if (state_o !== s)
			summarize();
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		chk("state", 12'h001, state_o);
		chk("low power", 1'b1, low_power_o);
		rx_info0_i = 1'b1;
		tick(2);
		rx_info0_i = 1'b0;
		chk("state", 12'h001, state_o);
		chk("line tx", 4'h0, line_tx_o);
		ce_i = 1'b0;
		rx_info1_i = 1'b1;
		tick(2);
		chk("frozen state", 12'h001, state_o);
		chk("frozen line tx", 4'h0, line_tx_o);
		rx_info1_i = 1'b0;
		ce_i = 1'b1;
		$display("test reset done");
	endtask
	task automatic t_user;
		rx_info1_i = 1'b1;
		tick(1);
		rx_info1_i = 1'b0;
		chk("line tx", 4'h1, line_tx_o);
		wait_st(12'h008, 4);
		chk("line tx", 4'h2, line_tx_o);
		wait_st(12'h010, 12);
		chk("line tx", 4'h3, line_tx_o);
		chk("user tx", 3'h2, user_tx_o);
		rx_info3_i = 1'b1;
		tick(1);
		rx_info3_i = 1'b0;
		chk("line tx", 4'h4, line_tx_o);
		wait_st(12'h040, 8);
		user_data_i = 18'h2a5c3;
		line_data_i = 18'h15a3c;
		user_decho_i = 1'b1;
		tick(2);
		chk("line tx", 4'h5, line_tx_o);
		chk("user tx", 3'h4, user_tx_o);
		chk("line data", 18'h2a5c3, line_data_o);
		chk("user data", 18'h15a3c, user_data_o);
		chk("decho", 1'b1, user_decho_o);
		chk("exchange ind", 1'b0, lt_act);
		user_decho_i = 1'b0;
		user_frame_lost_i = 1'b1;
		tick(1);
		user_frame_lost_i = 1'b0;
		chk("state", 12'h100, state_o);
		rx_info3_i = 1'b1;
		tick(1);
		rx_info3_i = 1'b0;
		chk("state", 12'h040, state_o);
		line_frame_lost_i = 1'b1;
		tick(1);
		line_frame_lost_i = 1'b0;
		chk("user tx", 3'h7, user_tx_o);
		drop = 1'b1;
		tick(1);
		chk("state", 12'h080, state_o);
		wait_st(12'h001, T2 + 3);
		chk("t2 span", 1'b1, n >= T2);
		drop = 1'b0;
		$display("test user wake done");
	endtask
	task automatic t_line;
		loop = 1'b1;
		wake = 1'b1;
		tick(1);
		wake = 1'b0;
		tick(2);
		chk("state", 12'h004, state_o);
		hi = 0;
		repeat (8)
		begin
			tick(1);
			hi += int'(line_tone_o);
		end
		chk("tone", 1'b1, hi > 0 && hi < 8);
		wake = 1'b1;
		tick(1);
		wake = 1'b0;
		rx_sig2l2_i = 1'b1;
		wait_st(12'h400, TN1 + 8);
		chk("tn1 span", 1'b1, n >= TN1);
		chk("line tx", 4'h4, line_tx_o);
		rx_sig2l2_i = 1'b0;
		wait_st(12'h800, 8);
		line_data_i = 18'h3c5a1;
		user_decho_i = 1'b1;
		tick(2);
		chk("loop data", 18'h3c5a1, line_data_o);
		chk("decho", 1'b0, user_decho_o);
		loop = 1'b0;
		wait_st(12'h040, 6);
		drop = 1'b1;
		tick(1);
		rx_info0_i = 1'b1;
		tick(1);
		chk("state", 12'h001, state_o);
		rx_info0_i = 1'b0;
		drop = 1'b0;
		$display("test line wake done");
	endtask
	initial
	begin
		forever #5 clock_i = ~clock_i;
	end
	initial
	begin
		repeat (6) @(posedge clock_i);
		#1;
		rstn_i = 1'b1;
		t_reset();
		t_user();
		t_line();
		summarize();
	end
endmodule
